// [rtl/dlc_bank.sv]
/*
 * dpll loop configuration bank: feedback path control, loop rate divider,
 * three loop filter coefficients and the read-only frequency estimate.
 * assumes the register port, the estimator and the loop filter all run on i_mclk;
 * only the feedback pin comes from outside and is synchronised inside dlc_fb_div.
 */
// Chosen here: strobed register access.
module dlc_bank (
   // clock and reset
   input  wire logic                i_mclk,
   input  wire logic                i_rst_n,
   // register port
   input  wire dlc_pkg::dlc_bus_t   i_bus,
   output logic [7:0]               o_rdata,
   // feedback path
   input  wire logic                i_fb_in,
   input  wire logic [15:0]         i_fb_div_value,
   output logic                     o_fb_div_pulse,
   // loop filter
   output logic                     o_loop_tick,
   output dlc_pkg::dlc_coef_t       o_coef,
   // frequency estimator
   input  wire logic [31:0]         i_freq_est
);

   // ==========================================================
   // storage
   logic        fb_invert_q;
   logic        fb_prescale_q;
   logic [4:0]  rate_q;
   logic [11:0] a_lin_q;
   logic [4:0]  a_mul_q;
   logic [2:0]  a_div_q;
   logic [11:0] b_lin_q;
   logic [2:0]  b_div_q;
   logic [11:0] c_lin_q;
   logic [2:0]  c_div_q;
   logic [7:0]  rdata_q;
   logic        wr;
   logic [15:0] waddr;
   logic [7:0]  wdata;

   assign wr    = i_bus.wr;
   assign waddr = i_bus.addr;
   assign wdata = i_bus.wdata;

   // ==========================================================
   // feedback control
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         fb_invert_q   <= 1'b0;
         fb_prescale_q <= 1'b0;
      end else if (wr && waddr == dlc_pkg::DLC_ADDR_FB_CTRL) begin
         fb_invert_q   <= wdata[dlc_pkg::DLC_FB_INV_BIT]; // RULE1
         fb_prescale_q <= wdata[dlc_pkg::DLC_FB_PRE_BIT]; // RULE2
      end
   end

   // ==========================================================
   // loop rate
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         rate_q <= dlc_pkg::DLC_RATE_RST; // RULE5
      end else if (wr && waddr == dlc_pkg::DLC_ADDR_LOOP_RATE) begin
         rate_q <= wdata[dlc_pkg::DLC_RATE_W-1:0]; // RULE4
      end
   end

   // ==========================================================
   // coefficient a
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         a_lin_q <= '0;
         a_mul_q <= '0;
         a_div_q <= '0;
      end else if (wr) begin
         unique case (waddr)
            dlc_pkg::DLC_ADDR_A_LIN_LO: begin
               a_lin_q[7:0] <= wdata; // RULE13
            end
            dlc_pkg::DLC_ADDR_A_LIN_HI: begin
               a_lin_q[11:8] <= wdata[dlc_pkg::DLC_LIN_HI_W-1:0]; // RULE7
            end
            dlc_pkg::DLC_ADDR_A_MUL: begin
               a_mul_q <= wdata[dlc_pkg::DLC_MUL_W-1:0]; // RULE7
            end
            dlc_pkg::DLC_ADDR_A_DIV: begin
               a_div_q <= wdata[dlc_pkg::DLC_DIV_W-1:0]; // RULE7
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // coefficient b
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         b_lin_q <= '0;
         b_div_q <= '0;
      end else if (wr) begin
         unique case (waddr)
            dlc_pkg::DLC_ADDR_B_LIN_LO: begin
               b_lin_q[7:0] <= wdata; // RULE13
            end
            dlc_pkg::DLC_ADDR_B_LIN_HI: begin
               b_lin_q[11:8] <= wdata[dlc_pkg::DLC_LIN_HI_W-1:0]; // RULE8
            end
            dlc_pkg::DLC_ADDR_B_DIV: begin
               b_div_q <= wdata[dlc_pkg::DLC_DIV_W-1:0]; // RULE8
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // coefficient c
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         c_lin_q <= '0;
         c_div_q <= '0;
      end else if (wr) begin
         unique case (waddr)
            dlc_pkg::DLC_ADDR_C_LIN_LO: begin
               c_lin_q[7:0] <= wdata; // RULE13
            end
            dlc_pkg::DLC_ADDR_C_LIN_HI: begin
               c_lin_q[11:8] <= wdata[dlc_pkg::DLC_LIN_HI_W-1:0]; // RULE9
            end
            dlc_pkg::DLC_ADDR_C_DIV: begin
               c_div_q <= wdata[dlc_pkg::DLC_DIV_W-1:0]; // RULE9
            end
            default: begin
            end
         endcase
      end
   end

   // coefficient fields leave as one registered bundle
   assign o_coef.a_linear     = a_lin_q;
   assign o_coef.a_mult_shift = a_mul_q;
   assign o_coef.a_div_shift  = a_div_q;
   assign o_coef.b_linear     = b_lin_q;
   assign o_coef.b_div_shift  = b_div_q;
   assign o_coef.c_linear     = c_lin_q;
   assign o_coef.c_div_shift  = c_div_q;

   // ==========================================================
   // read path
   // read data stand only in the cycle after the strobe, zero otherwise;
   // reserved and unmapped offsets read zero, writes to them are dropped
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         rdata_q <= dlc_pkg::DLC_BYTE_ZERO;
      end else if (!i_bus.rd) begin
         rdata_q <= dlc_pkg::DLC_BYTE_ZERO;
      end else begin
         unique case (i_bus.addr)
            dlc_pkg::DLC_ADDR_FB_CTRL: begin
               rdata_q <= {fb_invert_q, 6'h00, fb_prescale_q}; // RULE13
            end
            dlc_pkg::DLC_ADDR_LOOP_RATE: begin
               rdata_q <= {3'h0, rate_q}; // RULE13
            end
            dlc_pkg::DLC_ADDR_A_LIN_LO: begin
               rdata_q <= a_lin_q[7:0];
            end
            dlc_pkg::DLC_ADDR_A_LIN_HI: begin
               rdata_q <= {4'h0, a_lin_q[11:8]};
            end
            dlc_pkg::DLC_ADDR_A_MUL: begin
               rdata_q <= {3'h0, a_mul_q};
            end
            dlc_pkg::DLC_ADDR_A_DIV: begin
               rdata_q <= {5'h00, a_div_q};
            end
            dlc_pkg::DLC_ADDR_B_LIN_LO: begin
               rdata_q <= b_lin_q[7:0];
            end
            dlc_pkg::DLC_ADDR_B_LIN_HI: begin
               rdata_q <= {4'h0, b_lin_q[11:8]};
            end
            dlc_pkg::DLC_ADDR_B_DIV: begin
               rdata_q <= {5'h00, b_div_q};
            end
            dlc_pkg::DLC_ADDR_C_LIN_LO: begin
               rdata_q <= c_lin_q[7:0];
            end
            dlc_pkg::DLC_ADDR_C_LIN_HI: begin
               rdata_q <= {4'h0, c_lin_q[11:8]};
            end
            dlc_pkg::DLC_ADDR_C_DIV: begin
               rdata_q <= {5'h00, c_div_q};
            end
            // estimate is live from the estimator; bytes of one word may come
            // from different samples if it moves between reads
            dlc_pkg::DLC_ADDR_EST_B0: begin
               rdata_q <= i_freq_est[7:0]; // RULE10
            end
            dlc_pkg::DLC_ADDR_EST_B1: begin
               rdata_q <= i_freq_est[15:8]; // RULE10
            end
            dlc_pkg::DLC_ADDR_EST_B2: begin
               rdata_q <= i_freq_est[23:16]; // RULE10
            end
            dlc_pkg::DLC_ADDR_EST_B3: begin
               rdata_q <= i_freq_est[31:24]; // RULE10
            end
            default: begin
               rdata_q <= dlc_pkg::DLC_BYTE_ZERO; // RULE13
            end
         endcase
      end
   end

   assign o_rdata = rdata_q;

   // ==========================================================
   // datapath blocks
   dlc_fb_div u_fb_div (
      .i_mclk     (i_mclk),
      .i_rst_n    (i_rst_n),
      .i_fb_in    (i_fb_in),
      .i_invert   (fb_invert_q),
      .i_prescale (fb_prescale_q),
      .i_ratio    (i_fb_div_value),
      .o_pulse_q  (o_fb_div_pulse)
   );

   // loop tick divides the system clock itself, no converter clock of its own
   dlc_rate_div u_rate_div (
      .i_mclk   (i_mclk), // RULE6
      .i_rst_n  (i_rst_n),
      .i_rate   (rate_q),
      .o_tick_q (o_loop_tick)
   );

   // ==========================================================
   // checks
   property p_rate_reset;
      @(posedge i_mclk)
      !i_rst_n |=> rate_q == dlc_pkg::DLC_RATE_RST;
   endproperty
   a_rate_reset: assert property (p_rate_reset) else $error("rate not 5 after reset"); // RULE5

   property p_rate_readback;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (wr && waddr == dlc_pkg::DLC_ADDR_LOOP_RATE)
      ##1 (i_bus.rd && i_bus.addr == dlc_pkg::DLC_ADDR_LOOP_RATE && !wr)
      |=> o_rdata == {3'h0, $past(wdata, 2) & 8'h1f};
   endproperty
   a_rate_readback: assert property (p_rate_readback) else $error("rate readback wrong"); // RULE4

   property p_fb_ctrl_readback;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (wr && waddr == dlc_pkg::DLC_ADDR_FB_CTRL)
      ##1 (i_bus.rd && i_bus.addr == dlc_pkg::DLC_ADDR_FB_CTRL && !wr)
      |=> o_rdata == ($past(wdata, 2) & 8'h81);
   endproperty
   a_fb_ctrl_readback: assert property (p_fb_ctrl_readback) else $error("fb control readback wrong"); // RULE13

   property p_est_read;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_bus.rd && i_bus.addr == dlc_pkg::DLC_ADDR_EST_B3)
      |=> o_rdata == $past(i_freq_est[31:24]);
   endproperty
   a_est_read: assert property (p_est_read) else $error("estimate top byte wrong"); // RULE10

   property p_est_low;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_bus.rd && i_bus.addr == dlc_pkg::DLC_ADDR_EST_B0)
      |=> o_rdata == $past(i_freq_est[7:0]);
   endproperty
   a_est_low: assert property (p_est_low) else $error("estimate low byte wrong"); // RULE10

   property p_reserved_zero;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_bus.rd && i_bus.addr >= 16'h0112 && i_bus.addr <= 16'h0114) |=> o_rdata == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved byte not zero"); // RULE13

   property p_a_hi_read;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_bus.rd && i_bus.addr == dlc_pkg::DLC_ADDR_A_LIN_HI) |=> o_rdata[7:4] == 4'h0;
   endproperty
   a_a_hi_read: assert property (p_a_hi_read) else $error("coef a high nibble not zero"); // RULE7

   property p_b_div_width;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (wr && waddr == dlc_pkg::DLC_ADDR_B_DIV) |=> o_coef.b_div_shift == $past(wdata[2:0]);
   endproperty
   a_b_div_width: assert property (p_b_div_width) else $error("coef b divide shift wrong"); // RULE8

   property p_c_lin_pair;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (wr && waddr == dlc_pkg::DLC_ADDR_C_LIN_LO) ##1 (wr && waddr == dlc_pkg::DLC_ADDR_C_LIN_HI)
      |=> o_coef.c_linear == {$past(wdata[3:0]), $past(wdata, 2)};
   endproperty
   a_c_lin_pair: assert property (p_c_lin_pair) else $error("coef c linear pairing wrong"); // RULE9

   property p_rdata_idle;
      @(posedge i_mclk) disable iff (!i_rst_n)
      !i_bus.rd |=> o_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot"); // RULE13

endmodule

// [shared/dlc_pkg.sv]
/*
 * constants, field layouts and carrier types for the dpll loop configuration bank.
 * assumes one system clock for the whole bank and an 8-bit register port.
 */
// Overview of operation
// RULE1: feedback control bit 7 makes the feedback divider count falling input edges.
// RULE2: feedback control bit 0 adds a divide-by-two stage before the feedback divider.
// RULE3: software sets the prescaler above ratio 65,536 or inputs above 400 MHz.
// RULE4: loop filter tick rate is system clock over two to the 5-bit field.
// RULE5: loop rate field resets to 5, giving a divide by 32.
// RULE6: loop filter rate derives from the system clock, no separate converter clock.
// RULE7: coefficient a is 12-bit linear, 5-bit multiply shift, 3-bit divide shift.
// RULE8: coefficient b is 12-bit linear with a 3-bit divide shift.
// RULE9: coefficient c is 12-bit linear with a 3-bit divide shift.
// RULE10: frequency estimate reads as four bytes from 0x0115, low byte first, writes ignored.
// RULE11: software leaves 0x0112 to 0x0114 alone; they hold nothing.
// RULE12: feedback divide ratio is the programmed 16-bit value plus one.
// RULE13: low address holds the low byte; bits outside fields read zero.
package dlc_pkg;

   // ==========================================================
   // register offsets
   localparam logic [15:0] DLC_ADDR_FB_CTRL   = 16'h0106;
   localparam logic [15:0] DLC_ADDR_LOOP_RATE = 16'h0107;
   localparam logic [15:0] DLC_ADDR_A_LIN_LO  = 16'h0108;
   localparam logic [15:0] DLC_ADDR_A_LIN_HI  = 16'h0109;
   localparam logic [15:0] DLC_ADDR_A_MUL     = 16'h010a;
   localparam logic [15:0] DLC_ADDR_A_DIV     = 16'h010b;
   localparam logic [15:0] DLC_ADDR_B_LIN_LO  = 16'h010c;
   localparam logic [15:0] DLC_ADDR_B_LIN_HI  = 16'h010d;
   localparam logic [15:0] DLC_ADDR_B_DIV     = 16'h010e;
   localparam logic [15:0] DLC_ADDR_C_LIN_LO  = 16'h010f;
   localparam logic [15:0] DLC_ADDR_C_LIN_HI  = 16'h0110;
   localparam logic [15:0] DLC_ADDR_C_DIV     = 16'h0111;
   localparam logic [15:0] DLC_ADDR_EST_B0    = 16'h0115;
   localparam logic [15:0] DLC_ADDR_EST_B1    = 16'h0116;
   localparam logic [15:0] DLC_ADDR_EST_B2    = 16'h0117;
   localparam logic [15:0] DLC_ADDR_EST_B3    = 16'h0118;

   // ==========================================================
   // field positions and widths
   localparam int          DLC_FB_INV_BIT  = 7;
   localparam int          DLC_FB_PRE_BIT  = 0;
   localparam int          DLC_RATE_W      = 5;
   localparam int          DLC_LIN_W       = 12;
   localparam int          DLC_LIN_HI_W    = 4;
   localparam int          DLC_MUL_W       = 5;
   localparam int          DLC_DIV_W       = 3;
   localparam int          DLC_FBDIV_W     = 16;
   localparam int          DLC_EST_W       = 32;
   localparam int          DLC_TICK_CNT_W  = 31;

   // ==========================================================
   // reset values
   localparam logic [4:0]  DLC_RATE_RST    = 5'h05;
   localparam logic [7:0]  DLC_BYTE_ZERO   = 8'h00;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } dlc_bus_t;

   typedef struct packed {
      logic [11:0] a_linear;
      logic [4:0]  a_mult_shift;
      logic [2:0]  a_div_shift;
      logic [11:0] b_linear;
      logic [2:0]  b_div_shift;
      logic [11:0] c_linear;
      logic [2:0]  c_div_shift;
   } dlc_coef_t;

   // low bits that must all be set for a tick at divide 2^rate
   function automatic logic [30:0] dlc_pow2_mask(input logic [4:0] rate);
      logic [30:0] m;
      m = '0;
      for (int i = 0; i < DLC_TICK_CNT_W; i++) begin
         m[i] = (i < int'(rate));
      end
      return m;
   endfunction

endpackage

// [rtl/dlc_rate_div.sv]
/*
 * loop filter sample tick: one pulse every 2^rate system clocks.
 * assumes the rate field comes from a register on the same clock.
 */
module dlc_rate_div (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // control
   input  wire logic [4:0]  i_rate,
   // tick
   output logic             o_tick_q
);

   logic [30:0] cnt_q;

   // ==========================================================
   // free running count; a rate change only moves the next tick
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 31'h1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_tick_q <= 1'b0;
      end else begin
         o_tick_q <= ((cnt_q & dlc_pkg::dlc_pow2_mask(i_rate))
                      == dlc_pkg::dlc_pow2_mask(i_rate)); // RULE4
      end
   end

   // ==========================================================
   // checks
   property p_tick_div8;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (o_tick_q && i_rate == 5'h03) ##1 (i_rate == 5'h03) [*8] |-> o_tick_q && !$past(o_tick_q);
   endproperty
   a_tick_div8: assert property (p_tick_div8) else $error("tick period not 8"); // RULE4

   property p_tick_div1;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_rate == 5'h00) [*2] |-> o_tick_q;
   endproperty
   a_tick_div1: assert property (p_tick_div1) else $error("tick missing at rate 0"); // RULE4

endmodule

// [rtl/dlc_fb_div.sv]
/*
 * feedback path: pin synchroniser, edge select, optional /2, divide by value+1.
 * assumes the feedback pin is slow enough to be oversampled by the system clock.
 */
module dlc_fb_div (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // feedback pin
   input  wire logic        i_fb_in,
   // control
   input  wire logic        i_invert,
   input  wire logic        i_prescale,
   input  wire logic [15:0] i_ratio,
   // divided output
   output logic             o_pulse_q
);

   logic        s1_q;
   logic        s2_q;
   logic        s3_q;
   logic        half_q;
   logic [15:0] cnt_q;
   logic        evt;
   logic        pass;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= i_fb_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign evt  = i_invert ? (s3_q & ~s2_q) : (s2_q & ~s3_q); // RULE1
   assign pass = evt & (~i_prescale | half_q); // RULE2

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         half_q <= 1'b0;
      end else if (evt && i_prescale) begin
         half_q <= ~half_q; // RULE2
      end
   end

   // >= keeps the count bounded when software lowers the ratio mid-count
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         cnt_q     <= '0;
         o_pulse_q <= 1'b0;
      end else begin
         o_pulse_q <= pass && (cnt_q >= i_ratio); // RULE12
         if (pass) begin
            cnt_q <= (cnt_q >= i_ratio) ? 16'h0000 : cnt_q + 16'h0001; // RULE12
         end
      end
   end

   property p_fb_fall;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_invert && !i_prescale && i_ratio == 16'h0000 && s3_q && !s2_q) |=> o_pulse_q;
   endproperty
   a_fb_fall: assert property (p_fb_fall) else $error("falling edge not counted"); // RULE1

   property p_fb_rise_ignored;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_invert && !(s3_q && !s2_q)) |=> !o_pulse_q;
   endproperty
   a_fb_rise_ignored: assert property (p_fb_rise_ignored) else $error("pulse without falling edge"); // RULE1

   property p_fb_pre_swallow;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_prescale && !half_q) |=> !o_pulse_q;
   endproperty
   a_fb_pre_swallow: assert property (p_fb_pre_swallow) else $error("prescaler passed an edge"); // RULE2

   property p_fb_wrap;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (pass && cnt_q == i_ratio) |=> (o_pulse_q && cnt_q == 16'h0000);
   endproperty
   a_fb_wrap: assert property (p_fb_wrap) else $error("divider did not wrap at value"); // RULE12

endmodule

// [sim/tb_dlc_bank.sv]
/*
 * self-checking bench for dlc_bank: register map, masks, estimate bytes,
 * loop tick spacing and feedback divider pulse counts.
 * assumes the dlc_pkg field layout and the hand-over timing of the register port.
 */
module tb_dlc_bank;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // signals
   logic                i_mclk;
   logic                i_rst_n;
   dlc_pkg::dlc_bus_t   bus;
   logic [7:0]          o_rdata;
   logic                fb_pin;
   logic [15:0]         fb_value;
   logic                o_fb_div_pulse;
   logic                o_loop_tick;
   dlc_pkg::dlc_coef_t  o_coef;
   logic [31:0]         est;
   logic [7:0]          sh [32];
   int                  num_errors;
   int                  checks_done;
   int                  pulses;
   int                  gap;
   logic [7:0]          rd;

   dlc_bank dut (
      .i_mclk         (i_mclk),
      .i_rst_n        (i_rst_n),
      .i_bus          (bus),
      .o_rdata        (o_rdata),
      .i_fb_in        (fb_pin),
      .i_fb_div_value (fb_value),
      .o_fb_div_pulse (o_fb_div_pulse),
      .o_loop_tick    (o_loop_tick),
      .o_coef         (o_coef),
      .i_freq_est     (est)
   );

   initial i_mclk = 1'b0;
   always #2.5 i_mclk = ~i_mclk;

   // counting high cycles also catches a pulse that stands too long
   always @(posedge i_mclk) begin
      if (o_fb_div_pulse === 1'b1) pulses++;
   end

   // ==========================================================
   // checking and closing
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      wrap_up();
   end

   // ==========================================================
   // expectations
   function automatic logic [7:0] fmask(input logic [15:0] a);
      case (a)
         16'h0106:                     return 8'h81;
         16'h0107, 16'h010a:           return 8'h1f;
         16'h0108, 16'h010c, 16'h010f: return 8'hff;
         16'h0109, 16'h010d, 16'h0110: return 8'h0f;
         16'h010b, 16'h010e, 16'h0111: return 8'h07;
         default:                      return 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] exp_rd(input logic [15:0] a);
      if (a >= 16'h0115 && a <= 16'h0118) return 8'(est >> (8 * (a - 16'h0115)));
      return sh[a[4:0]] & fmask(a);
   endfunction

   function automatic dlc_pkg::dlc_coef_t exp_coef();
      return '{a_linear: {sh[9][3:0], sh[8]}, a_mult_shift: sh[10][4:0],
               a_div_shift: sh[11][2:0], b_linear: {sh[13][3:0], sh[12]},
               b_div_shift: sh[14][2:0], c_linear: {sh[16][3:0], sh[15]},
               c_div_shift: sh[17][2:0]};
   endfunction

   // ==========================================================
   // register port
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
      sh[a[4:0]] = d;
   endtask

   // write straight into a read of the same offset, no idle cycle between
   task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      sh[a[4:0]] = d;
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      #1 q = o_rdata;
   endtask

   // low and high byte of a linear field in two back-to-back writes
   task automatic wr_pair(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: d0, wr: 1'b1, rd: 1'b0};
      @(posedge i_mclk);
      bus <= '{addr: 16'(a + 16'h0001), wdata: d1, wr: 1'b1, rd: 1'b0};
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      sh[a[4:0]] = d0;
      sh[a[4:0] + 5'h01] = d1;
   endtask

   task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      #1 d = o_rdata;
   endtask

   // reads the whole window including unmapped 0x105 and 0x119
   task automatic check_all();
      for (int a = 16'h0105; a <= 16'h0119; a++) begin
         rd_reg(16'(a), rd);
         chk(rd, exp_rd(16'(a)));
      end
      chk(o_coef, exp_coef());
   endtask

   task automatic do_reset();
      @(posedge i_mclk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      foreach (sh[i]) sh[i] = 8'h00;
      sh[7] = 8'h05;
   endtask

   // the first gap after a rate change may be short, so the second one counts
   task automatic tick_gap(output int n);
      for (int r = 0; r < 2; r++) begin
         n = 0;
         while (o_loop_tick !== 1'b1 && n < 100) begin
            @(posedge i_mclk);
            #1;
            n++;
         end
         n = 0;
         do begin
            @(posedge i_mclk);
            #1;
            n++;
         end while (o_loop_tick !== 1'b1 && n < 100);
      end
   endtask

   // pin high and low three clocks each; spurious edges from the config write are let pass
   task automatic fb_run(input logic [15:0] v, input logic [7:0] ctrl, input int edges,
                         input int exp);
      do_reset();
      wr_reg(16'h0106, ctrl);
      fb_value <= v;
      repeat (8) @(posedge i_mclk);
      pulses = 0;
      repeat (edges) begin
         @(posedge i_mclk);
         fb_pin <= 1'b1;
         repeat (3) @(posedge i_mclk);
         fb_pin <= 1'b0;
         repeat (2) @(posedge i_mclk);
      end
      repeat (8) @(posedge i_mclk);
      chk(pulses, exp);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      i_rst_n = 1'b0;
      bus = '0;
      fb_pin = 1'b0;
      fb_value = 16'h0000;
      est = 32'h0;
      num_errors = 0;
      checks_done = 0;
      pulses = 0;
      void'($urandom(12395));
      est = $urandom;
      do_reset();
      check_all();
      tick_gap(gap);
      chk(gap, 32);
      repeat (3) begin
         for (int a = 16'h0105; a <= 16'h0119; a++) wr_reg(16'(a), 8'($urandom));
         est <= $urandom;
         check_all();
      end
      wr_pair(16'h010f, 8'($urandom), 8'($urandom));
      wr_pair(16'h0108, 8'($urandom), 8'($urandom));
      wr_rd(16'h0106, 8'($urandom), rd);
      chk(rd, sh[6] & 8'h81);
      wr_rd(16'h0107, 8'($urandom), rd);
      chk(rd, sh[7] & 8'h1f);
      check_all();
      for (int r = 0; r < 6; r++) begin
         wr_reg(16'h0107, 8'($urandom) & 8'he0 | 8'(r));
         tick_gap(gap);
         chk(gap, 1 << r);
      end
      fb_run(16'h0000, 8'h00, 5, 5);
      fb_run(16'h0002, 8'h00, 9, 3);
      fb_run(16'h0001, 8'h01, 8, 2);
      fb_run(16'h0003, 8'h80, 8, 2);
      fb_run(16'h0000, 8'h81, 6, 3);
      // with inversion the rising edge does not count, and the prescaler swallows the next falling edge
      @(posedge i_mclk);
      fb_pin <= 1'b1;
      repeat (8) @(posedge i_mclk);
      chk(pulses, 3);
      fb_pin <= 1'b0;
      repeat (8) @(posedge i_mclk);
      chk(pulses, 3);
      wrap_up();
   end
endmodule
